// >>> common/rfa_pkg.sv
// package of the register file and data-space addressing block
// assumes one clock domain; shared by the core and its address generator
package rfa_pkg;

    // =========================================================
    // data-space map
    localparam int          REG_COUNT   = 32;
    localparam int          SRAM_SIZE   = 512;
    localparam logic [15:0] IO_BASE     = 16'h0020;
    localparam logic [15:0] SRAM_BASE   = 16'h0060;
    localparam logic [15:0] SRAM_END    = 16'h0260;
    localparam logic [5:0]  SP_LOW_IO   = 6'h3d;
    localparam logic [5:0]  SP_HIGH_IO  = 6'h3e;

    // =========================================================
    // widths and reset values
    localparam int          SP_W        = 10;
    localparam int          PC_W        = 12;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [9:0]  SP_RESET    = 10'h000;
    localparam logic [11:0] PC_RESET    = 12'h000;
    localparam logic [15:0] FETCH_NOP   = 16'h0000;

    // =========================================================
    // pointer pair bases (low byte register index)
    localparam logic [4:0]  PTR_A_LOW   = 5'h1a;
    localparam logic [4:0]  PTR_B_LOW   = 5'h1c;
    localparam logic [4:0]  PTR_C_LOW   = 5'h1e;
    localparam logic [1:0]  SEL_A       = 2'h0;
    localparam logic [1:0]  SEL_B       = 2'h1;
    localparam logic [1:0]  SEL_C       = 2'h2;

    // =========================================================
    // access modes
    localparam logic [3:0]  MODE_DIRECT   = 4'h0;
    localparam logic [3:0]  MODE_IO       = 4'h1;
    localparam logic [3:0]  MODE_INDIRECT = 4'h2;
    localparam logic [3:0]  MODE_DISP     = 4'h3;
    localparam logic [3:0]  MODE_PREDEC   = 4'h4;
    localparam logic [3:0]  MODE_POSTINC  = 4'h5;
    localparam logic [3:0]  MODE_PUSH     = 4'h6;
    localparam logic [3:0]  MODE_POP      = 4'h7;
    localparam logic [3:0]  MODE_CONST    = 4'h8;

    // =========================================================
    // timing and interrupts
    localparam int          SRAM_ACCESS_CYCLES = 2;
    localparam int          IRQ_COUNT   = 16;
    localparam logic [11:0] IRQ_VEC_BASE = 12'h001;

    // access engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } rfa_state_type;

    // what the wait cycle completes
    typedef enum logic [1:0] {
        KIND_SRAM  = 2'h0,
        KIND_IO    = 2'h1,
        KIND_CONST = 2'h2
    } rfa_kind_type;

    // joins a register pair into a pointer
    function automatic logic [15:0] pair16(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction : pair16

endpackage : rfa_pkg

// >>> logic/rfa_agu.sv
// operand address generator for data-space and stack accesses
// purely combinational; the core registers everything it produces
`timescale 1ns/10ps
`default_nettype none
module rfa_agu (
    // request fields
    input  wire logic [3:0]  mode,
    input  wire logic [1:0]  ptr_sel,
    input  wire logic [5:0]  disp,
    input  wire logic [5:0]  io_field,
    input  wire logic [15:0] direct_addr,
    // pointer and stack state
    input  wire logic [15:0] ptr_a,
    input  wire logic [15:0] ptr_b,
    input  wire logic [15:0] ptr_c,
    input  wire logic [9:0]  sp,
    // results
    output logic [15:0]      addr,
    output logic             ptr_wb,
    output logic [4:0]       ptr_wb_base,
    output logic [15:0]      ptr_wb_val,
    output logic             sp_wb,
    output logic [9:0]       sp_wb_val
);

    logic [15:0] ptr_val;

    // =========================================================
    // address and writeback selection
    always_comb
    begin
        ptr_val     = (ptr_sel == rfa_pkg::SEL_A) ? ptr_a :
                      (ptr_sel == rfa_pkg::SEL_B) ? ptr_b : ptr_c;
        ptr_wb_base = (ptr_sel == rfa_pkg::SEL_A) ? rfa_pkg::PTR_A_LOW :
                      (ptr_sel == rfa_pkg::SEL_B) ? rfa_pkg::PTR_B_LOW : rfa_pkg::PTR_C_LOW;
        addr        = ptr_val;
        ptr_wb      = 1'b0;
        ptr_wb_val  = ptr_val;
        sp_wb       = 1'b0;
        sp_wb_val   = sp;
        case (mode)
            rfa_pkg::MODE_DIRECT:   addr = direct_addr;
            rfa_pkg::MODE_IO:       addr = rfa_pkg::IO_BASE + {10'h000, io_field};
            rfa_pkg::MODE_INDIRECT: addr = ptr_val;
            rfa_pkg::MODE_DISP:
            begin
                // only pointer_b or pointer_c serve as base
                addr = ((ptr_sel == rfa_pkg::SEL_B) ? ptr_b : ptr_c)
                       + {10'h000, disp};
            end
            rfa_pkg::MODE_PREDEC:
            begin
                addr       = ptr_val - 16'h0001;
                ptr_wb     = 1'b1;
                ptr_wb_val = ptr_val - 16'h0001;
            end
            rfa_pkg::MODE_POSTINC:
            begin
                addr       = ptr_val;
                ptr_wb     = 1'b1;
                ptr_wb_val = ptr_val + 16'h0001;
            end
            rfa_pkg::MODE_PUSH:
            begin
                addr      = {6'h00, sp};
                sp_wb     = 1'b1;
                sp_wb_val = sp - 10'h001;
            end
            rfa_pkg::MODE_POP:
            begin
                addr      = {6'h00, sp + 10'h001};
                sp_wb     = 1'b1;
                sp_wb_val = sp + 10'h001;
            end
            default:                addr = ptr_c;
        endcase
    end

endmodule : rfa_agu
`default_nettype wire

// >>> logic/rfa_core.sv
// working register file, data-space decode, fetch stage and irq priority
// assumes the decoder sequences requests and writes loaded bytes back itself
`timescale 1ns/10ps
`default_nettype none
module rfa_core (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // alu operand port
    input  wire logic [4:0]  src_sel,
    input  wire logic [4:0]  dst_sel,
    input  wire logic        imm_op,
    input  wire logic        alu_wr_en,
    input  wire logic [7:0]  alu_wr_data,
    output logic [7:0]       dst_operand,
    output logic [7:0]       source_operand_reg,
    // data-space access request
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [3:0]  mem_mode,
    input  wire logic [1:0]  ptr_sel,
    input  wire logic [5:0]  disp,
    input  wire logic [5:0]  io_field,
    input  wire logic [15:0] direct_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic             mem_busy,
    output logic             mem_done,
    output logic [7:0]       mem_rdata,
    output logic [15:0]      mem_addr,
    // peripheral I/O port
    output logic             io_sel,
    output logic             io_we,
    output logic [5:0]       io_index,
    output logic [7:0]       io_wdata,
    input  wire logic [7:0]  io_rdata,
    // program memory fetch
    input  wire logic        pc_load,
    input  wire logic [11:0] pc_target,
    input  wire logic        fetch_hold,
    input  wire logic [15:0] prog_data,
    output logic [11:0]      prog_addr,
    output logic [15:0]      instr_word,
    // constant lookup port
    output logic [11:0]      const_addr,
    input  wire logic [15:0] const_data,
    // stack and interrupts
    output logic [9:0]       stack_top_pointer,
    input  wire logic [15:0] irq_pending,
    output logic             irq_valid,
    output logic [11:0]      irq_vector
);

    // =========================================================
    // storage
    logic [7:0] regs      [rfa_pkg::REG_COUNT];
    logic [7:0] next_regs [rfa_pkg::REG_COUNT];
    logic [7:0] sram      [rfa_pkg::SRAM_SIZE];
    logic [7:0] sram_q;

    rfa_pkg::rfa_state_type state, next_state;
    rfa_pkg::rfa_kind_type  kind, next_kind;

    logic        const_hi, next_const_hi;
    logic        next_busy, next_done;
    logic [7:0]  next_rdata;
    logic [15:0] next_addr;
    logic        next_io_sel, next_io_we;
    logic [5:0]  next_io_index;
    logic [7:0]  next_io_wdata;
    logic [11:0] next_const_addr;
    logic [9:0]  next_sp;
    logic [7:0]  next_dst_operand, next_src_operand;
    logic [11:0] next_pc;
    logic [15:0] next_instr;
    logic        next_irq_valid;
    logic [11:0] next_irq_vector;

    // register-file and SRAM write requests from the access engine
    logic        dwr_en;
    logic [4:0]  dwr_idx;
    logic        pwr_en;
    logic [4:0]  pwr_base;
    logic [15:0] pwr_val;
    logic        sram_we;
    logic [8:0]  sram_idx;

    logic [4:0]  dst_eff;
    logic [15:0] ptr_a, ptr_b, ptr_c;
    logic [15:0] agu_addr, io_off, sram_off;
    logic        agu_ptr_wb, agu_sp_wb;
    logic [4:0]  agu_ptr_base;
    logic [15:0] agu_ptr_val;
    logic [9:0]  agu_sp_val;

    // =========================================================
    // pointer views of the upper registers
    assign ptr_a = rfa_pkg::pair16(regs[27], regs[26]);
    assign ptr_b = rfa_pkg::pair16(regs[29], regs[28]);
    assign ptr_c = rfa_pkg::pair16(regs[31], regs[30]);

    // immediate forms fold the destination into the upper half
    assign dst_eff = imm_op ? {1'b1, dst_sel[3:0]} : dst_sel;

    assign io_off   = agu_addr - rfa_pkg::IO_BASE;
    assign sram_off = agu_addr - rfa_pkg::SRAM_BASE;

    rfa_agu u_agu (
        .mode        (mem_mode),
        .ptr_sel     (ptr_sel),
        .disp        (disp),
        .io_field    (io_field),
        .direct_addr (direct_addr),
        .ptr_a       (ptr_a),
        .ptr_b       (ptr_b),
        .ptr_c       (ptr_c),
        .sp          (stack_top_pointer),
        .addr        (agu_addr),
        .ptr_wb      (agu_ptr_wb),
        .ptr_wb_base (agu_ptr_base),
        .ptr_wb_val  (agu_ptr_val),
        .sp_wb       (agu_sp_wb),
        .sp_wb_val   (agu_sp_val)
    );

    // =========================================================
    // access engine next state
    always_comb
    begin
        next_state      = state;
        next_kind       = kind;
        next_const_hi   = const_hi;
        next_busy       = 1'b0;
        next_done       = 1'b0;
        next_rdata      = mem_rdata;
        next_addr       = mem_addr;
        next_io_sel     = 1'b0;
        next_io_we      = 1'b0;
        next_io_index   = io_index;
        next_io_wdata   = io_wdata;
        next_const_addr = const_addr;
        next_sp         = stack_top_pointer;
        dwr_en          = 1'b0;
        dwr_idx         = agu_addr[4:0];
        pwr_en          = 1'b0;
        pwr_base        = agu_ptr_base;
        pwr_val         = agu_ptr_val;
        sram_we         = 1'b0;
        sram_idx        = sram_off[8:0];
        unique case (state)
            rfa_pkg::ST_IDLE:
            begin
                if (mem_req)
                begin
                    next_addr = agu_addr;
                    pwr_en    = agu_ptr_wb;
                    if (agu_sp_wb)
                        next_sp = agu_sp_val;
                    if (mem_mode == rfa_pkg::MODE_CONST)
                    begin
                        next_const_addr = ptr_c[12:1];
                        next_const_hi   = ptr_c[0];
                        next_kind       = rfa_pkg::KIND_CONST;
                        next_busy       = 1'b1;
                        next_state      = rfa_pkg::ST_WAIT;
                    end
                    else if (agu_addr < rfa_pkg::IO_BASE)
                    begin
                        // register hit reads and writes the live file
                        next_rdata = regs[agu_addr[4:0]];
                        dwr_en     = mem_we;
                        next_done  = 1'b1;
                    end
                    else if (agu_addr < rfa_pkg::SRAM_BASE)
                    begin
                        // stack pointer lives in I/O space here
                        if (io_off[5:0] == rfa_pkg::SP_LOW_IO)
                        begin
                            next_rdata = stack_top_pointer[7:0];
                            if (mem_we)
                                next_sp = {stack_top_pointer[9:8], mem_wdata};
                            next_done = 1'b1;
                        end
                        else if (io_off[5:0] == rfa_pkg::SP_HIGH_IO)
                        begin
                            next_rdata = {6'h00, stack_top_pointer[9:8]};
                            if (mem_we)
                                next_sp = {mem_wdata[1:0], stack_top_pointer[7:0]};
                            next_done = 1'b1;
                        end
                        else
                        begin
                            next_io_sel   = 1'b1;
                            next_io_we    = mem_we;
                            next_io_index = io_off[5:0];
                            next_io_wdata = mem_wdata;
                            next_kind     = rfa_pkg::KIND_IO;
                            next_busy     = 1'b1;
                            next_state    = rfa_pkg::ST_WAIT;
                        end
                    end
                    else if (agu_addr < rfa_pkg::SRAM_END)
                    begin
                        sram_we    = mem_we;
                        next_kind  = rfa_pkg::KIND_SRAM;
                        next_busy  = 1'b1;
                        next_state = rfa_pkg::ST_WAIT;
                    end
                    else
                    begin
                        // unmapped space reads as zero
                        next_rdata = 8'h00;
                        next_done  = 1'b1;
                    end
                end
            end
            rfa_pkg::ST_WAIT:
            begin
                // second cycle completes slow accesses
                next_state = rfa_pkg::ST_IDLE;
                next_done  = 1'b1;
                unique case (kind)
                    rfa_pkg::KIND_SRAM:  next_rdata = sram_q;
                    rfa_pkg::KIND_IO:    next_rdata = io_rdata;
                    rfa_pkg::KIND_CONST: next_rdata = const_hi ? const_data[15:8]
                                                               : const_data[7:0];
                    default:             next_rdata = 8'h00;
                endcase
            end
        endcase
    end

    // access engine registers
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state             <= rfa_pkg::ST_IDLE;
            kind              <= rfa_pkg::KIND_SRAM;
            const_hi          <= 1'b0;
            mem_busy          <= 1'b0;
            mem_done          <= 1'b0;
            mem_rdata         <= 8'h00;
            mem_addr          <= 16'h0000;
            io_sel            <= 1'b0;
            io_we             <= 1'b0;
            io_index          <= 6'h00;
            io_wdata          <= 8'h00;
            const_addr        <= 12'h000;
            stack_top_pointer <= rfa_pkg::SP_RESET;
        end
        else
        begin
            state             <= next_state;
            kind              <= next_kind;
            const_hi          <= next_const_hi;
            mem_busy          <= next_busy;
            mem_done          <= next_done;
            mem_rdata         <= next_rdata;
            mem_addr          <= next_addr;
            io_sel            <= next_io_sel;
            io_we             <= next_io_we;
            io_index          <= next_io_index;
            io_wdata          <= next_io_wdata;
            const_addr        <= next_const_addr;
            stack_top_pointer <= next_sp;
        end
    end

    // internal SRAM: write and read latch at the accept edge
    always_ff @(posedge ref_clk)
    begin
        if (sram_we)
            sram[sram_idx] <= mem_wdata;
        sram_q <= sram[sram_idx];
    end

    // =========================================================
    // register file next state: alu, then pointer, then data writes
    always_comb
    begin
        next_regs = regs;
        if (alu_wr_en)
            next_regs[dst_eff] = alu_wr_data;
        if (pwr_en)
        begin
            next_regs[pwr_base]          = pwr_val[7:0];
            next_regs[pwr_base + 5'h01]  = pwr_val[15:8];
        end
        if (dwr_en)
            next_regs[dwr_idx] = mem_wdata;
        next_dst_operand = regs[dst_eff];
        next_src_operand = regs[src_sel];
    end

    // register file registers
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < rfa_pkg::REG_COUNT; i++)
                regs[i] <= rfa_pkg::REG_RESET;
            dst_operand        <= 8'h00;
            source_operand_reg <= 8'h00;
        end
        else
        begin
            regs               <= next_regs;
            dst_operand        <= next_dst_operand;
            source_operand_reg <= next_src_operand;
        end
    end

    // =========================================================
    // fetch stage: next word fetched while the current one executes
    always_comb
    begin
        next_pc    = prog_addr;
        next_instr = instr_word;
        if (!fetch_hold)
        begin
            if (pc_load)
            begin
                next_pc    = pc_target;
                next_instr = rfa_pkg::FETCH_NOP;                   // flush stale word
            end
            else
            begin
                next_pc    = prog_addr + 12'h001;
                next_instr = prog_data;
            end
        end
    end

    // fetch registers
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prog_addr  <= rfa_pkg::PC_RESET;
            instr_word <= rfa_pkg::FETCH_NOP;
        end
        else
        begin
            prog_addr  <= next_pc;
            instr_word <= next_instr;
        end
    end

    // =========================================================
    // interrupt priority: lowest pending index wins
    always_comb
    begin
        next_irq_valid  = 1'b0;
        next_irq_vector = rfa_pkg::IRQ_VEC_BASE;
        for (int i = rfa_pkg::IRQ_COUNT - 1; i >= 0; i--)
        begin
            if (irq_pending[i])
            begin
                next_irq_valid  = 1'b1;
                next_irq_vector = rfa_pkg::IRQ_VEC_BASE + 12'(i);
            end
        end
    end

    // interrupt registers
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_valid  <= 1'b0;
            irq_vector <= rfa_pkg::IRQ_VEC_BASE;
        end
        else
        begin
            irq_valid  <= next_irq_valid;
            irq_vector <= next_irq_vector;
        end
    end

endmodule : rfa_core
`default_nettype wire

// >>> testbench/rfa_partner.sv
// far-side model of rfa_core: program, peripheral and constant memory
// answers combinationally in the cycle the core asks
`timescale 1ns/10ps
`default_nettype none
module rfa_partner (
    // addresses from the core
    input  wire logic [11:0] prog_addr, const_addr,
    input  wire logic [5:0]  io_index,
    // answers
    output logic [15:0]      prog_data, const_data,
    output logic [7:0]       io_rdata
);
    // each word carries its own address, so a wrong address shows
    assign prog_data  = {4'ha, prog_addr};
    assign const_data = {4'hc, const_addr};
    assign io_rdata   = {2'h0, io_index} ^ 8'ha5;
endmodule : rfa_partner
`default_nettype wire

// >>> testbench/rfa_core_properties.sv
// timing checks of rfa_core data access, fetch and interrupt ports
// bound to every rfa_core; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module rfa_core_properties (
    // clock, reset and watched ports
    input wire logic        ref_clk, sys_rst, mem_busy, mem_done, io_sel, pc_load, fetch_hold,
    input wire logic        irq_valid, io_we,
    input wire logic [11:0] pc_target, prog_addr, irq_vector,
    input wire logic [15:0] prog_data, instr_word, irq_pending
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_slow; mem_busy |=> mem_done && !mem_busy; endproperty
    a_slow: assert property (p_slow) else $error("slow access late");
    property p_io; io_sel |-> mem_busy ##1 mem_done; endproperty
    a_io: assert property (p_io) else $error("io access late");
    property p_step; !fetch_hold && !pc_load |=> prog_addr == $past(prog_addr) + 12'h001; endproperty
    a_step: assert property (p_step) else $error("fetch address");
    property p_iowe; io_we |-> io_sel; endproperty
    a_iowe: assert property (p_iowe) else $error("io write without strobe");
    property p_load; !fetch_hold && pc_load |=> prog_addr == $past(pc_target) && instr_word == 16'h0000; endproperty
    a_load: assert property (p_load) else $error("jump load");
    property p_word; !fetch_hold && !pc_load |=> instr_word == $past(prog_data); endproperty
    a_word: assert property (p_word) else $error("fetched word");
    property p_hold; fetch_hold && !pc_load |=> $stable(prog_addr) && $stable(instr_word); endproperty
    a_hold: assert property (p_hold) else $error("fetch hold");
    property p_prio; irq_pending[1:0] == 2'b10 |=> irq_valid && irq_vector == 12'h002; endproperty
    a_prio: assert property (p_prio) else $error("irq priority");
    property p_idle; irq_pending == 16'h0000 |=> !irq_valid; endproperty
    a_idle: assert property (p_idle) else $error("irq without cause");
endmodule : rfa_core_properties
bind rfa_core rfa_core_properties u_rfa_core_properties (.ref_clk, .sys_rst, .mem_busy,
    .mem_done, .io_sel, .pc_load, .fetch_hold, .irq_valid, .pc_target, .prog_addr,
    .irq_vector, .prog_data, .instr_word, .irq_pending, .io_we);
`default_nettype wire

// >>> testbench/rfa_core_tb.sv
// bench of rfa_core: register file, data accesses, fetch and interrupts
// inputs change on the falling edge; memories come from rfa_partner
`timescale 1ns/10ps
`default_nettype none
module rfa_core_tb;
    logic ref_clk = 0, sys_rst = 1, imm_op = 0, alu_wr_en = 0, mem_req = 0, mem_we = 0;
    logic pc_load = 0, fetch_hold = 0, mem_busy, mem_done, io_sel, io_we, irq_valid;
    logic [7:0] io_wdata;
    logic [1:0] ptr_sel = 0;
    logic [3:0] mem_mode = 0;
    logic [4:0] src_sel = 0, dst_sel = 0;
    logic [5:0] disp = 0, io_field = 0, io_index;
    logic [7:0] alu_wr_data = 0, mem_wdata = 0, dst_operand, source_operand_reg, mem_rdata, io_rdata;
    logic [9:0] stack_top_pointer;
    logic [11:0] pc_target = 0, prog_addr, const_addr, irq_vector;
    logic [15:0] direct_addr = 0, irq_pending = 0, mem_addr, prog_data, instr_word, const_data;
    int fail_count = 0, n_compared = 0, lat;
    rfa_core u_rfa_core (.ref_clk, .sys_rst, .src_sel, .dst_sel, .imm_op, .alu_wr_en,
        .alu_wr_data, .dst_operand, .source_operand_reg, .mem_req, .mem_we, .mem_mode, .ptr_sel,
        .disp, .io_field, .direct_addr, .mem_wdata, .mem_busy, .mem_done, .mem_rdata, .mem_addr,
        .io_sel, .io_we, .io_index, .io_wdata, .io_rdata, .pc_load, .pc_target, .fetch_hold,
        .prog_data, .prog_addr, .instr_word, .const_addr, .const_data, .stack_top_pointer,
        .irq_pending, .irq_valid, .irq_vector);
    rfa_partner u_rfa_partner (.prog_addr, .const_addr, .io_index, .prog_data, .const_data,
        .io_rdata);
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [4:0] r, input logic [7:0] v);
        dst_sel = r; alu_wr_data = v; alu_wr_en = 1; @(negedge ref_clk) alu_wr_en = 0;
        // idle edge so a following call does not re-raise the strobe in this step
        @(negedge ref_clk);
    endtask : wr
    task automatic rd(input logic [4:0] r, input logic [7:0] e);
        src_sel = r; @(negedge ref_clk) chk(source_operand_reg, e);
    endtask : rd
    // one data access, requested for one cycle, then a bounded wait for completion
    task automatic acc(input logic [3:0] m, input logic we, input logic [7:0] wd, e);
        mem_mode = m; mem_we = we; mem_wdata = wd; mem_req = 1;
        @(negedge ref_clk) mem_req = 0;
        for (lat = 1; mem_done !== 1'b1; lat++)
            if (lat > 8)
            begin
                fail_count++;
                wrap_up();
            end
            else
                @(negedge ref_clk);
        chk(16'(lat), e);
        // idle edge so a following call does not re-raise mem_req in this step
        @(negedge ref_clk);
    endtask : acc
    task automatic t_regs;
        for (int i = 0; i < 32; i++) wr(5'(i), 8'(8'h40 + i));
        for (int i = 0; i < 32; i++)
        begin
            dst_sel = 5'(31 - i); rd(5'(i), 8'(8'h40 + i));
            chk(dst_operand, 8'(8'h5f - i));
        end
        imm_op = 1; wr(5'h05, 8'hee); imm_op = 0; rd(5'h15, 8'hee); rd(5'h05, 8'h45);
    endtask : t_regs
    task automatic t_mem;
        wr(5'h1a, 8'h03); wr(5'h1b, 8'h00); ptr_sel = 0;
        acc(4'h2, 0, 0, 1); chk(mem_rdata, 8'h43);
        acc(4'h5, 0, 0, 1); rd(5'h1a, 8'h04);
        acc(4'h4, 0, 0, 1); chk(mem_addr, 16'h0003); rd(5'h1a, 8'h03);
        direct_addr = 16'h0002; acc(4'h0, 1, 8'h99, 1); rd(5'h02, 8'h99);
        direct_addr = 16'h011f; acc(4'h0, 1, 8'h5c, 2);
        wr(5'h1c, 8'he0); wr(5'h1d, 8'h00); ptr_sel = 1; disp = 6'h3f;
        acc(4'h3, 0, 0, 2); chk(mem_rdata, 8'h5c);
        io_field = 6'h05; acc(4'h1, 0, 0, 2); chk(mem_rdata, 8'ha0);
        acc(4'h1, 1, 8'h3c, 2); chk(io_wdata, 8'h3c); chk(io_index, 6'h05);
        io_field = 6'h3d; acc(4'h1, 1, 8'h80, 1);
        acc(4'h6, 1, 8'h77, 2); chk(stack_top_pointer, 10'h07f);
        acc(4'h7, 0, 0, 2); chk(mem_rdata, 8'h77);
        wr(5'h1e, 8'h07); wr(5'h1f, 8'h00);
        acc(4'h8, 0, 0, 2); chk(mem_rdata, 8'hc0); chk(const_addr, 12'h003);
        wr(5'h1e, 8'h00); wr(5'h1f, 8'h01); ptr_sel = 2;
        acc(4'h4, 0, 0, 2); rd(5'h1e, 8'hff); rd(5'h1f, 8'h00);
    endtask : t_mem
    task automatic t_misc;
        pc_target = 12'hfff; pc_load = 1; @(negedge ref_clk) pc_load = 0;
        chk(prog_addr, 12'hfff); chk(instr_word, 16'h0000);
        fetch_hold = 1; @(negedge ref_clk) fetch_hold = 0;
        chk(prog_addr, 12'hfff); irq_pending = 16'h0006;
        @(negedge ref_clk) chk(prog_addr, 12'h000); chk(instr_word, 16'hafff);
        chk(irq_vector, 12'h002); chk(irq_valid, 1'b1);
    endtask : t_misc
    initial
    begin
        repeat (10) @(negedge ref_clk);
        sys_rst = 0;
        t_regs(); t_mem(); t_misc();
        wrap_up();
    end
endmodule : rfa_core_tb
`default_nettype wire
